/* hbp_host_port.sv */
// host processor bus port: decode, register store and buffer control
module hbp_host_port
    import hbp_pkg::*;
(
    // clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  resetn,
    input  wire logic                  power_on_reset_n,
    // mode straps
    input  wire logic                  host_bus_mode_sel_2,
    input  wire logic                  host_bus_mode_sel_1,
    input  wire logic                  host_bus_mode_sel_0,
    // host strobes
    input  wire logic                  chip_select_n,
    input  wire logic                  read_strobe_n,
    input  wire logic                  write_strobe_n,
    input  wire logic                  addr_latch_en,
    // dedicated address
    input  wire logic [HBP_ADDR_W-1:0] host_addr,
    // shared data / address bus
    input  wire logic [HBP_DATA_W-1:0] ad_in,
    output logic      [HBP_DATA_W-1:0] ad_out,
    output logic                       ad_oe,
    // core side
    output logic                       core_soft_reset,
    output logic                       mode_reserved,
    output logic [HBP_SPACES*HBP_SPACE_SZ*HBP_DATA_W-1:0] reg_image
);
    localparam int NREG = HBP_SPACES * HBP_SPACE_SZ;
    localparam int SW   = 4 + 3 + HBP_ADDR_W + HBP_DATA_W;

    logic [SW-1:0]         sync_in;
    logic [SW-1:0]         sync_out;
    hbp_strobe_type        stb;
    logic [2:0]            mode_pins;
    logic [HBP_ADDR_W-1:0] addr_s;
    logic [HBP_DATA_W-1:0] ad_s;
    logic                  por_s;
    logic                  por_meta_r;
    logic                  por_r;

    // strobes, straps, address and bus cross together, so they stay aligned
    assign sync_in = {chip_select_n,
                      read_strobe_n,
                      write_strobe_n,
                      addr_latch_en,
                      host_bus_mode_sel_2,
                      host_bus_mode_sel_1,
                      host_bus_mode_sel_0,
                      host_addr,
                      ad_in};

    hbp_sync #(.W(SW)) u_sync (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .d       (sync_in),
        .q       (sync_out)
    );

    assign {stb, mode_pins, addr_s, ad_s} = sync_out;

    // power reset pin crossing, resets low (asserted) style
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            por_meta_r <= 1'b0;
            por_r      <= 1'b0;
        end else begin
            por_meta_r <= power_on_reset_n;
            por_r      <= por_meta_r;
        end
    end
    assign por_s = por_r;

    // mode decode
    function automatic hbp_mode_type dec_mode(input logic [2:0] m);
        case (m)
            HBP_MODE_NMX: dec_mode = HBP_NMX;
            HBP_MODE_MUX: dec_mode = HBP_MUX;
            HBP_MODE_STB: dec_mode = HBP_STB;
            3'h2, 3'h3:   dec_mode = HBP_BAD;
            3'h5:         dec_mode = HBP_BAD;
            // 11X is undefined and refused as well
            default:      dec_mode = HBP_BAD;
        endcase
    endfunction : dec_mode

    hbp_mode_type mode;
    assign mode          = dec_mode(mode_pins);
    assign mode_reserved = (mode == HBP_BAD);

    // strobe interpretation per mode
    logic sel;
    logic stb_mode;
    logic rd_req_plain;
    logic wr_req_plain;
    logic rd_req_dir;
    logic wr_req_dir;
    logic rd_act;
    logic wr_act;
    logic wr_act_r;

    // a reserved strap code or a low power reset blinds the port
    assign sel      = !stb.cs_n && por_s && !mode_reserved;
    assign stb_mode = (mode == HBP_STB);

    // plain modes: separate active-low read and write pulses
    assign rd_req_plain = !stb.rd_n;
    assign wr_req_plain = !stb.wr_n;

    // direction mode: read pin gives direction, write pin strobes
    assign rd_req_dir = stb.rd_n && !stb.wr_n;
    assign wr_req_dir = !stb.rd_n && !stb.wr_n;

    assign rd_act = sel && (stb_mode ? rd_req_dir : rd_req_plain);
    assign wr_act = sel && (stb_mode ? wr_req_dir : wr_req_plain);

    // address capture
    logic                  ale_take;
    logic [HBP_ADDR_W-1:0] mux_addr_r;
    logic [HBP_ADDR_W-1:0] mux_addr_nxt;
    logic [HBP_ADDR_W-1:0] eff_addr;

    // an address phase only counts while the port is selected
    assign ale_take     = stb.ale && !stb.cs_n;
    assign mux_addr_nxt = ale_take ? ad_s[HBP_ADDR_W-1:0]
                                   : mux_addr_r;
    assign eff_addr = (mode == HBP_MUX) ? mux_addr_r
                                        : addr_s;

    always_ff @(posedge sys_clk) begin
        if (!resetn || !por_s) begin
            mux_addr_r <= '0;
        end else begin
            mux_addr_r <= mux_addr_nxt;
        end
    end

    // space and byte select
    logic                  space_sel;
    logic [HBP_BYTE_W-1:0] byte_sel;
    logic [3:0]            reg_idx;

    // address bit 3 is not decoded: only two spaces exist
    assign space_sel = eff_addr[HBP_ADDR_W-1];
    assign byte_sel  = eff_addr[HBP_BYTE_W-1:0];
    assign reg_idx   = {space_sel, byte_sel};

    // register store
    logic [HBP_DATA_W-1:0] regs_r [NREG];
    logic [HBP_DATA_W-1:0] wdata_r;
    logic [3:0]            widx_r;
    logic                  wr_fire;

    // commit on the trailing edge: data and index were held from the
    // last active cycle, so a write ended by chip select still lands
    assign wr_fire = wr_act_r && !wr_act;

    always_ff @(posedge sys_clk) begin
        if (!resetn || !por_s) begin
            wr_act_r <= 1'b0;
            wdata_r  <= HBP_REG_RST;
            widx_r   <= '0;
        end else begin
            wr_act_r <= wr_act;
            if (wr_act) begin
                wdata_r <= ad_s;
                widx_r  <= reg_idx;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn || !por_s) begin
            for (int i = 0; i < NREG; i++) begin
                regs_r[i] <= HBP_REG_RST;
            end
            regs_r[HBP_CTRL_ADR[3:0]][HBP_SRST_BIT] <= 1'b1;
        end else if (wr_fire) begin
            regs_r[widx_r] <= wdata_r;
        end
    end

    always_comb begin
        for (int i = 0; i < NREG; i++) begin
            reg_image[i*HBP_DATA_W +: HBP_DATA_W] = regs_r[i];
        end
    end
    assign core_soft_reset = regs_r[HBP_CTRL_ADR[3:0]][HBP_SRST_BIT];

    // read path and buffer enable
    // read data follows the addressed byte one cycle late, so when address and
    // strobe cross together it settles one cycle after the enable opens
    logic [HBP_DATA_W-1:0] rdata_r;
    logic                  oe_core;
    logic                  oe_pin_gate;

    always_ff @(posedge sys_clk) begin
        if (!resetn || !por_s) begin
            rdata_r <= '0;
        end else begin
            rdata_r <= regs_r[reg_idx];
        end
    end
    assign ad_out = rdata_r;

    // a selected read outside the address phase opens the buffers
    assign oe_core     = rd_act && !stb.ale && por_s;
    // raw pin gate floats the bus at once, ahead of the crossing
    assign oe_pin_gate = power_on_reset_n;
    assign ad_oe       = oe_core && oe_pin_gate;
    // ad_oe is the only output enable and falls with power reset
endmodule : hbp_host_port

/* hbp_pkg.sv */
// package for the host processor bus port
// Summary of operation
// - straps 000 pick split address and data, 100 the shared bus.
// - straps 001 make read a direction pin and write a data strobe.
// - in split mode the host puts a 5-bit address on the address pins.
// - address bit 4 picks one of two 8-byte spaces, bits 2:0 the byte.
// - in shared mode the address comes from shared lines 4:0.
// - the address latch strobe marks the address cycle, captured then.
// - data lines are driven only during a read: read strobe low, or with straps 001 read high and write low.
// - power reset leaves the core in soft reset until software clears it.
// - while power reset is low the data lines float.
// - the active-low write pulse marks a write and data is taken on it.
// - chip select is active low and strobes count only while it is low.
package hbp_pkg;
    localparam int          HBP_ADDR_W   = 5;
    localparam int          HBP_DATA_W   = 8;
    localparam int          HBP_BYTE_W   = 3;
    localparam int          HBP_SPACES   = 2;
    localparam int          HBP_SPACE_SZ = 8;
    localparam logic [2:0]  HBP_MODE_NMX = 3'h0;
    localparam logic [2:0]  HBP_MODE_STB = 3'h1;
    localparam logic [2:0]  HBP_MODE_MUX = 3'h4;
    localparam logic [7:0]  HBP_REG_RST  = 8'h00;
    // space 0 byte 0 bit 0 holds the core soft-reset control
    localparam logic [4:0]  HBP_CTRL_ADR = 5'h00;
    localparam int          HBP_SRST_BIT = 0;

    typedef enum logic [1:0] {
        HBP_NMX, HBP_STB, HBP_MUX, HBP_BAD
    } hbp_mode_type;

    typedef struct packed {
        logic       cs_n;
        logic       rd_n;
        logic       wr_n;
        logic       ale;
    } hbp_strobe_type;
endpackage : hbp_pkg

/* hbp_sync.sv */
// two-flop synchroniser bank for pin inputs
module hbp_sync
    import hbp_pkg::*;
#(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         sys_clk,
    input  wire logic         resetn,
    // data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_r;

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            meta_r <= '0;
            q      <= '0;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule : hbp_sync

/* hbp_chk.sv */
// assertion checker for the host bus port
module hbp_chk
    import hbp_pkg::*;
(
    // clock and resets
    input wire logic        sys_clk,
    input wire logic        resetn,
    input wire logic        power_on_reset_n,
    // straps and strobes
    input wire logic        host_bus_mode_sel_2,
    input wire logic        host_bus_mode_sel_1,
    input wire logic        host_bus_mode_sel_0,
    input wire logic        chip_select_n,
    input wire logic        read_strobe_n,
    input wire logic        write_strobe_n,
    input wire logic        addr_latch_en,
    // outputs
    input wire logic        ad_oe,
    input wire logic        core_soft_reset,
    input wire logic        mode_reserved,
    input wire logic [HBP_SPACES*HBP_SPACE_SZ*HBP_DATA_W-1:0] reg_image
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    logic [2:0] mode_w;
    logic       rd_w;
    logic [3:0] wr_age_r;
    assign mode_w = {host_bus_mode_sel_2, host_bus_mode_sel_1,
                     host_bus_mode_sel_0};
    assign rd_w = !chip_select_n && !read_strobe_n && !addr_latch_en
                  && power_on_reset_n && mode_w == HBP_MODE_NMX;
    // cycles since a selected write strobe or a power reset
    always_ff @(posedge sys_clk) begin
        if (!resetn || !power_on_reset_n
            || !(chip_select_n || write_strobe_n)) begin
            wr_age_r <= 4'h0;
        end else if (wr_age_r != 4'hF) begin
            wr_age_r <= wr_age_r + 4'h1;
        end
    end
    a_por_float: assert property (!power_on_reset_n |-> !ad_oe)
        else $error("data bus driven in power reset");
    a_read_drives: assert property (rd_w [*3] |-> ad_oe)
        else $error("read not driving bus");
    a_oe_nmx_read: assert property (
        ad_oe && mode_w == HBP_MODE_NMX
        |-> $past(!chip_select_n && !read_strobe_n, 2))
        else $error("bus driven without read");
    a_oe_stb_dir: assert property (
        ad_oe && mode_w == HBP_MODE_STB
        |-> $past(read_strobe_n && !write_strobe_n, 2))
        else $error("bus driven without strobed read");
    a_oe_mux_ale: assert property (
        ad_oe && mode_w == HBP_MODE_MUX
        |-> $past(!addr_latch_en && !read_strobe_n, 2))
        else $error("bus driven in address phase");
    a_mode_decode: assert property ($stable(mode_w) [*4]
        |-> mode_reserved == (mode_w[1] | (mode_w[2] & mode_w[0])))
        else $error("mode decode wrong");
    a_soft_rst_por: assert property (!power_on_reset_n
        |-> ##[1:4] core_soft_reset)
        else $error("soft reset not set by power reset");
    a_reg_on_write: assert property (
        $changed(reg_image) |-> wr_age_r < 4'h8)
        else $error("register changed without write");
endmodule : hbp_chk

/* hbp_host_model.sv */
// host processor model driving the port pins
module hbp_host_model
    import hbp_pkg::*;
(
    // clock, strap view and bus view
    input  wire logic [2:0]       mode,
    input  wire logic             sys_clk,
    input  wire logic [7:0]       bus,
    // driven pins
    output hbp_strobe_type        stb,
    output logic [HBP_ADDR_W-1:0] addr,
    output logic [HBP_DATA_W-1:0] hd,
    output logic                  hoe
);
    initial begin
        stb = 4'hE;
        addr = 5'h00;
        hd = 8'h00;
        hoe = 1'b0;
    end
    task automatic acc(input logic sel, w, input logic [4:0] a,
                       input logic [7:0] d, output logic [7:0] q);
        addr <= a;
        if (mode == HBP_MODE_MUX) begin
            stb <= {!sel, 3'h7};
            hd <= {3'h0, a};
            hoe <= 1'b1;
            repeat (3) @(posedge sys_clk);
        end
        stb.cs_n <= !sel;
        stb.ale <= 1'b0;
        stb.rd_n <= (mode == HBP_MODE_STB) ? !w : w;
        stb.wr_n <= (mode == HBP_MODE_STB) ? 1'b0 : !w;
        hd <= d;
        hoe <= w;
        repeat (5) @(posedge sys_clk);
        q = bus;
        stb <= 4'hE;
        hoe <= 1'b0;
        repeat (3) @(posedge sys_clk);
    endtask : acc
endmodule : hbp_host_model

/* hbp_host_port_test.sv */
// testbench for the host bus port
module hbp_host_port_test
    import hbp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic           sys_clk = 1'b0;
    logic           resetn = 1'b0;
    logic           por_n = 1'b1;
    logic [2:0]     mode = HBP_MODE_NMX;
    hbp_strobe_type stb;
    logic [4:0]     addr, a;
    logic [7:0]     hd, ad_in, ad_out, q, d;
    logic           hoe, ad_oe, soft_rst, rsv;
    logic [127:0]   img;
    logic [7:0]     mem [16];
    logic [2:0]     bad [4] = '{3'h2, 3'h3, 3'h5, 3'h6};
    int             n_fail = 0;
    int             checks = 0;
    always #10 sys_clk = ~sys_clk;
    // released host lines show the inverse of their last value
    assign ad_in = ad_oe ? ad_out : (hoe ? hd : ~hd);
    hbp_host_port i_dut (.sys_clk(sys_clk), .resetn(resetn),
        .power_on_reset_n(por_n), .host_bus_mode_sel_2(mode[2]),
        .host_bus_mode_sel_1(mode[1]), .host_bus_mode_sel_0(mode[0]),
        .chip_select_n(stb.cs_n), .read_strobe_n(stb.rd_n),
        .write_strobe_n(stb.wr_n), .addr_latch_en(stb.ale),
        .host_addr(addr), .ad_in(ad_in), .ad_out(ad_out), .ad_oe(ad_oe),
        .core_soft_reset(soft_rst), .mode_reserved(rsv), .reg_image(img));
    hbp_host_model i_host (.mode(mode), .sys_clk(sys_clk), .bus(ad_in),
        .stb(stb), .addr(addr), .hd(hd), .hoe(hoe));
    task automatic chk(input string nm, input logic [7:0] got, exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    function automatic int ix(logic [4:0] x);
        return {x[4], x[2:0]};
    endfunction : ix
    task automatic put(input logic sel, input logic [4:0] x,
                       input logic [7:0] v);
        i_host.acc(sel, 1'b1, x, v, q);
        if (sel && mode inside {3'h0, 3'h1, 3'h4}) mem[ix(x)] = v;
    endtask : put
    task automatic look(input logic [4:0] x);
        i_host.acc(1'b1, 1'b0, x, 8'h00, q);
        chk("read data", q, mem[ix(x)]);
        chk("image byte", img[ix(x)*8 +: 8], mem[ix(x)]);
        chk("soft reset", {7'h0, soft_rst}, {7'h0, mem[0][0]});
    endtask : look
    task automatic report_and_stop();
        $display("checks %0d failures %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        #200000;
        n_fail++;
        report_and_stop();
    end
    initial begin
        void'($urandom(32'hE4CF));
        mem = '{default: 8'h00};
        mem[0] = 8'h01;
        repeat (5) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge sys_clk);
        for (int m = 0; m < 3; m++) begin
            mode <= (m == 0) ? HBP_MODE_NMX
                  : (m == 1) ? HBP_MODE_STB : HBP_MODE_MUX;
            repeat (4) @(posedge sys_clk);
            for (int i = 0; i < 8; i++) begin
                a = $urandom;
                d = $urandom;
                put(1'b1, a, d);
                look(a);
            end
            put(1'b0, a, ~d); // deselected write is ignored
            look(a);
            $display("mode test %0d done", m);
        end
        foreach (bad[k]) begin
            mode <= bad[k];
            repeat (4) @(posedge sys_clk);
            put(1'b1, a, ~d);
            chk("mode reserved", {7'h0, rsv}, 8'h01);
            mode <= HBP_MODE_NMX;
            repeat (4) @(posedge sys_clk);
            look(a);
        end
        $display("reserved mode test done");
        put(1'b1, 5'h00, 8'h00);
        look(5'h00);
        // power reset lands in the middle of a read
        fork
            i_host.acc(1'b1, 1'b0, 5'h00, 8'h00, q);
            begin
                repeat (3) @(posedge sys_clk);
                chk("bus enable", {7'h0, ad_oe}, 8'h01);
                por_n <= 1'b0;
                @(posedge sys_clk);
                chk("bus enable", {7'h0, ad_oe}, 8'h00);
            end
        join
        repeat (2) @(posedge sys_clk);
        chk("bus enable", {7'h0, ad_oe}, 8'h00);
        por_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        mem = '{default: 8'h00};
        mem[0] = 8'h01;
        look(5'h00);
        look(a);
        $display("power reset test done");
        report_and_stop();
    end
endmodule : hbp_host_port_test
bind hbp_host_port hbp_chk i_chk (.*);
